/* hw/lgto_top.sv */
// Legacy profile 1 to 4 emulation time-out register and the time-out it applies.
//
// Function
// - Eight-bit read/write register at 23h holds four two-bit profile time-out fields.
// - While profile 1 to 4 is applied, its own field sets the time-out.
// - Field code 00 selects 0.8 seconds, code 01 selects 1.6 seconds.
// - Field code 10 selects 6.4 seconds, code 11 selects 12.8 seconds.
// - With the global disable bit set, no field duration is applied at all.
// - Register contents are kept through sleep and unchanged on wake.
`timescale 1ns/1ps
`include "lgto_consts.svh"
module lgto_top
  import lgto_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `LGTO_TICK_CYC
) (
  input  wire logic       clock_in,
  input  wire logic       sys_rst_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  output logic            reg_rvalid_out,
  input  wire logic       dedicated_charger_emulation_in,
  input  wire logic [2:0] active_profile_in,
  input  wire logic       emulation_timeout_disable_in,
  input  wire logic       sleep_in,
  output logic      [1:0] profile1_timeout_sel_out,
  output logic      [1:0] profile2_timeout_sel_out,
  output logic      [1:0] profile3_timeout_sel_out,
  output logic      [1:0] profile4_timeout_sel_out,
  output logic      [1:0] emulation_timeout_sel_out,
  output logic            emulation_timeout_applied_out,
  output logic            emulation_timeout_running_out,
  output logic            emulation_timeout_expired_out
);

  // Converts a field code into a number of time-base ticks.
  function automatic lgto_ticks_t code_ticks(input lgto_code_t code);
    lgto_ticks_t t;
    t = 8'h00;
    unique case (code)
      LGTO_TO_0P8S:  t = 8'(`LGTO_TO_00_MS / `LGTO_TICK_MS);
      LGTO_TO_1P6S:  t = 8'(`LGTO_TO_01_MS / `LGTO_TICK_MS);
      LGTO_TO_6P4S:  t = 8'(`LGTO_TO_10_MS / `LGTO_TICK_MS);
      LGTO_TO_12P8S: t = 8'(`LGTO_TO_11_MS / `LGTO_TICK_MS);
    endcase
    return t;
  endfunction

  localparam int FIELD_LSB [1:4] = '{`LGTO_P1_LSB, `LGTO_P2_LSB, `LGTO_P3_LSB, `LGTO_P4_LSB};

  lgto_tmr_if tmr_bus ();

  logic [7:0]    timeout_reg_ff;
  logic [7:0]    nxt_timeout_reg;
  logic [7:0]    rdata_ff;
  logic          rvalid_ff;
  lgto_profile_t profile_ff;
  logic          applied_ff;
  logic [1:0]    sel_ff;
  logic [1:0]    field_sel [1:4];
  logic [4:1]    profile_hit;

  // Register decode.
  wire logic addr_hit  = (reg_addr_in == `LGTO_ADDR_TIMEOUT);
  wire logic wr_accept = reg_wr_in && addr_hit;
  wire logic rd_accept = reg_rd_in && addr_hit;

  // Writes only change the stored value; sleep has no effect on it.
  assign nxt_timeout_reg = wr_accept ? reg_wdata_in : timeout_reg_ff;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      timeout_reg_ff <= `LGTO_RST_TIMEOUT;
    end else begin
      timeout_reg_ff <= nxt_timeout_reg;
    end
  end

  // Reads of any other address return zero.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rdata_ff  <= `LGTO_RDATA_IDLE;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd_in;
      if (reg_rd_in) begin
        rdata_ff <= rd_accept ? timeout_reg_ff : `LGTO_RDATA_IDLE;
      end
    end
  end

  assign reg_rdata_out  = rdata_ff;
  assign reg_rvalid_out = rvalid_ff;

  // Field split and profile match, one slice per profile.
  genvar gi;
  generate
    for (gi = 1; gi <= 4; gi++) begin : g_field
      assign field_sel[gi]   = timeout_reg_ff[FIELD_LSB[gi] +: `LGTO_FIELD_W];
      assign profile_hit[gi] = (active_profile_in == 3'(gi));
    end
  endgenerate

  assign profile1_timeout_sel_out = field_sel[1];
  assign profile2_timeout_sel_out = field_sel[2];
  assign profile3_timeout_sel_out = field_sel[3];
  assign profile4_timeout_sel_out = field_sel[4];

  // Selected field of the running profile; zero when none of 1 to 4 is active.
  wire logic [1:0] cur_sel =
    ({2{profile_hit[1]}} & field_sel[1]) |
    ({2{profile_hit[2]}} & field_sel[2]) |
    ({2{profile_hit[3]}} & field_sel[3]) |
    ({2{profile_hit[4]}} & field_sel[4]);

  // A time-out applies only in the emulation cycle, for profiles 1 to 4,
  // and never while the global disable is set.
  wire logic applicable = dedicated_charger_emulation_in && (|profile_hit) &&
                          !emulation_timeout_disable_in;

  // A fresh time-out starts when the applied profile begins or changes.
  wire logic new_profile = applicable && (!applied_ff || (profile_ff != active_profile_in));

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      profile_ff <= 3'h0;
      applied_ff <= 1'b0;
      sel_ff     <= 2'h0;
    end else begin
      profile_ff <= active_profile_in;
      applied_ff <= applicable;
      if (new_profile) begin
        sel_ff <= cur_sel;
      end
    end
  end

  // The code latched at profile start is held for the whole time-out, so a
  // register write mid-emulation takes effect at the next profile.
  assign tmr_bus.start       = new_profile;
  assign tmr_bus.abort       = !applicable;
  assign tmr_bus.freeze      = sleep_in;
  assign tmr_bus.limit_ticks = code_ticks(lgto_code_t'(cur_sel));

  lgto_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .tmr        (tmr_bus.tmr)
  );

  assign emulation_timeout_sel_out     = sel_ff;
  assign emulation_timeout_applied_out = applied_ff;
  assign emulation_timeout_running_out = tmr_bus.running;
  assign emulation_timeout_expired_out = tmr_bus.expired;

endmodule

/* hw/lgto_consts.svh */
// Offsets, field positions, reset value and timing counts of the time-out register block.
`ifndef LGTO_CONSTS_SVH
`define LGTO_CONSTS_SVH

// Register address and power-on value.
`define LGTO_ADDR_TIMEOUT   8'h23
`define LGTO_RST_TIMEOUT    8'hB0
`define LGTO_RDATA_IDLE     8'h00

// Least significant bit of each profile field; each field is two bits wide.
`define LGTO_P1_LSB         6
`define LGTO_P2_LSB         4
`define LGTO_P3_LSB         2
`define LGTO_P4_LSB         0
`define LGTO_FIELD_W        2

// Clock rate and the time base of the time-out counter.
`define LGTO_CLK_HZ         10000000
`define LGTO_TICK_MS        100
`define LGTO_TICK_CYC       (`LGTO_TICK_MS * (`LGTO_CLK_HZ / 1000))

// Time-out durations in milliseconds for each field code.
`define LGTO_TO_00_MS       800
`define LGTO_TO_01_MS       1600
`define LGTO_TO_10_MS       6400
`define LGTO_TO_11_MS       12800

// Legacy profiles handled here.
`define LGTO_PROF_FIRST     3'h1
`define LGTO_PROF_LAST      3'h4

`endif

/* hw/lgto_pkg.sv */
// Types shared by the time-out register block.
package lgto_pkg;

  typedef enum logic [1:0] {
    LGTO_TO_0P8S  = 2'b00,
    LGTO_TO_1P6S  = 2'b01,
    LGTO_TO_6P4S  = 2'b10,
    LGTO_TO_12P8S = 2'b11
  } lgto_code_t;

  typedef enum logic [1:0] {
    LGTO_ST_IDLE = 2'b00,
    LGTO_ST_RUN  = 2'b01,
    LGTO_ST_DONE = 2'b10
  } lgto_state_t;

  typedef logic [2:0] lgto_profile_t;
  typedef logic [7:0] lgto_ticks_t;

endpackage

/* hw/lgto_tmr_if.sv */
// Control and status signals between the register block and its time-out counter.
`timescale 1ns/1ps
interface lgto_tmr_if;
  import lgto_pkg::*;

  logic        start;
  logic        abort;
  logic        freeze;
  lgto_ticks_t limit_ticks;
  logic        running;
  logic        expired;

  modport ctrl (
    output start,
    output abort,
    output freeze,
    output limit_ticks,
    input  running,
    input  expired
  );

  modport tmr (
    input  start,
    input  abort,
    input  freeze,
    input  limit_ticks,
    output running,
    output expired
  );
endinterface

/* hw/lgto_timer.sv */
// Time-out counter: counts whole time-base ticks up to a loaded limit.
`timescale 1ns/1ps
`include "lgto_consts.svh"
module lgto_timer
  import lgto_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `LGTO_TICK_CYC
) (
  input  wire logic   clock_in,
  input  wire logic   sys_rst_in,
  lgto_tmr_if.tmr     tmr
);

  localparam int DIV_W = $clog2(TICK_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

  lgto_state_t      state_ff;
  lgto_state_t      nxt_state;
  logic [DIV_W-1:0] div_ff;
  lgto_ticks_t      ticks_ff;
  lgto_ticks_t      limit_ff;
  logic             expired_ff;

  wire logic counting = (state_ff == LGTO_ST_RUN) && !tmr.freeze;
  wire logic tick_en  = counting && (div_ff == DIV_LAST);
  wire logic hit      = tick_en && (ticks_ff == limit_ff - 8'h01);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      LGTO_ST_IDLE: if (tmr.start) nxt_state = LGTO_ST_RUN;
      LGTO_ST_RUN: begin
        if (tmr.abort)      nxt_state = LGTO_ST_IDLE;
        else if (tmr.start) nxt_state = LGTO_ST_RUN;
        else if (hit)       nxt_state = LGTO_ST_DONE;
      end
      LGTO_ST_DONE: begin
        if (tmr.start)      nxt_state = LGTO_ST_RUN;
        else if (tmr.abort) nxt_state = LGTO_ST_IDLE;
      end
      default:              nxt_state = LGTO_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_ff   <= LGTO_ST_IDLE;
      div_ff     <= '0;
      ticks_ff   <= 8'h00;
      limit_ff   <= 8'h01;
      expired_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      expired_ff <= hit && !tmr.abort && !tmr.start;
      if (tmr.start) begin
        div_ff   <= '0;
        ticks_ff <= 8'h00;
        limit_ff <= tmr.limit_ticks;
      end else if (counting) begin
        div_ff <= tick_en ? '0 : div_ff + DIV_W'(1);
        if (tick_en) ticks_ff <= ticks_ff + 8'h01;
      end
    end
  end

  assign tmr.running = (state_ff == LGTO_ST_RUN);
  assign tmr.expired = expired_ff;

endmodule

/* dv/lgto_top_asserts.sv */
// Concurrent checks on the ports of the time-out register block.
`timescale 1ns/1ps
module lgto_top_asserts #(
  parameter int unsigned TICK_CYCLES = 2
) (
  input wire logic       clock_in,
  input wire logic       sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic       reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       reg_rvalid_out,
  input wire logic [2:0] active_profile_in,
  input wire logic       emulation_timeout_disable_in,
  input wire logic       sleep_in,
  input wire logic [1:0] profile1_timeout_sel_out,
  input wire logic [1:0] profile2_timeout_sel_out,
  input wire logic [1:0] profile3_timeout_sel_out,
  input wire logic [1:0] profile4_timeout_sel_out,
  input wire logic [1:0] emulation_timeout_sel_out,
  input wire logic       emulation_timeout_applied_out,
  input wire logic       emulation_timeout_running_out,
  input wire logic       emulation_timeout_expired_out
);
  logic [15:0] cnt_ff;
  wire  [7:0]  regv = {profile1_timeout_sel_out, profile2_timeout_sel_out,
                       profile3_timeout_sel_out, profile4_timeout_sel_out};
  wire  [1:0]  fsel = regv[{3'h4 - active_profile_in, 1'b0} +: 2];
  wire  [1:0]  s    = emulation_timeout_sel_out;
  wire  [15:0] lim  = 16'(TICK_CYCLES) * (s[1] ? (s[0] ? 16'h80 : 16'h40)
                                                : (s[0] ? 16'h10 : 16'h08));
  // Counts running cycles without sleep, so a paused count is judged fairly.
  wire  [15:0] nxt_cnt = emulation_timeout_running_out ? cnt_ff + {15'h0, !sleep_in} : 16'h0;
  always_ff @(posedge clock_in) begin
    cnt_ff <= sys_rst_in ? 16'h0 : nxt_cnt;
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_wr;
    reg_wr_in && reg_addr_in == 8'h23;
  endsequence
  chk_write_lands: assert property (s_wr |=> regv == $past(reg_wdata_in))
    else $error("register does not hold the written byte");
  chk_read_data: assert property (reg_rd_in |=> reg_rvalid_out && reg_rdata_out ==
    ($past(reg_addr_in) == 8'h23 ? $past(regv) : 8'h00))
    else $error("read answer wrong");
  chk_sel_latch: assert property ($rose(emulation_timeout_running_out) |->
    s == $past(fsel))
    else $error("time-out code not taken from the active profile field");
  chk_short_time: assert property (emulation_timeout_expired_out && !s[1] |-> cnt_ff == lim)
    else $error("short time-out length wrong");
  chk_long_time: assert property (emulation_timeout_expired_out && s[1] |-> cnt_ff == lim)
    else $error("long time-out length wrong");
  chk_reset_value: assert property ($past(sys_rst_in) |-> regv == 8'hB0 &&
    !emulation_timeout_running_out)
    else $error("reset value wrong");
  chk_disable_idle: assert property (emulation_timeout_disable_in |=>
    !emulation_timeout_running_out && !emulation_timeout_applied_out)
    else $error("time-out active while disabled");
  chk_sleep_keep: assert property (sleep_in && !reg_wr_in |=> $stable(regv))
    else $error("register changed during sleep");
endmodule
bind lgto_top lgto_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

/* dv/legacy_emulation_timeout_config_tb.sv */
// Self-checking bench for the time-out register block.
`timescale 1ns/1ps
module legacy_emulation_timeout_config_tb;
  localparam int TK = 2;
  logic       clock_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
  logic       dce = 0, dis = 0, slp = 0, rvalid, run, exp_p;
  logic [7:0] addr = 0, wdata = 0, rdata;
  logic [2:0] prof = 0;
  logic [1:0] sel, f1, f2, f3, f4;
  logic       appl;
  int         n_mismatch = 0, checks = 0, cyc = 0;
  initial forever #50 clock_in = ~clock_in;
  lgto_top #(.TICK_CYCLES(TK)) dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(addr), .reg_wr_in(reg_wr_in), .reg_wdata_in(wdata), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .dedicated_charger_emulation_in(dce),
    .active_profile_in(prof), .emulation_timeout_disable_in(dis), .sleep_in(slp),
    .profile1_timeout_sel_out(f1), .profile2_timeout_sel_out(f2),
    .profile3_timeout_sel_out(f3), .profile4_timeout_sel_out(f4),
    .emulation_timeout_sel_out(sel), .emulation_timeout_applied_out(appl),
    .emulation_timeout_running_out(run),
    .emulation_timeout_expired_out(exp_p));
  function automatic int want_cyc(input int code);
    int t[4] = '{8, 16, 64, 128};
    return t[code] * TK;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    checks++;
    if (got !== want) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    reg_wr_in = 1;
    @(negedge clock_in) reg_wr_in = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    addr = a;
    reg_rd_in = 1;
    @(negedge clock_in) reg_rd_in = 0;
    chk({rvalid, rdata}, {1'b1, want});
    // One idle cycle keeps back-to-back reads from re-raising the strobe in one step.
    @(negedge clock_in);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict;
    end
  end
  initial begin
    logic [7:0] v;
    int         n, got;
    void'($urandom(32'hEE445612));
    repeat (20) @(negedge clock_in);
    sys_rst_in = 0;
    rd(8'h23, 8'hB0);
    $display("test reset done");
    repeat (8) begin
      v = $urandom;
      wr(8'h23, v);
      rd(8'h23, v);
      chk({f1, f2, f3, f4}, v);
      wr(8'h23 ^ (8'($urandom) | 8'h01), ~v);
      rd(8'h23, v);
      rd(8'h23 ^ (8'($urandom) | 8'h01), 8'h00);
    end
    $display("test registers done");
    for (int p = 1; p <= 4; p++) begin
      for (int c = 0; c < 4; c++) begin
        v = $urandom;
        v[8 - 2 * p +: 2] = 2'(c);
        wr(8'h23, v);
        prof = 3'(p);
        dce = 1;
        n = 0;
        got = 0;
        while (exp_p !== 1'b1 && n < 1000) begin
          // Sleep set here is sampled at the next edge together with the state it gates.
          slp = ($urandom % 4 == 0);
          got += int'(run && !slp);
          @(negedge clock_in);
          n++;
        end
        chk(16'(got), 16'(want_cyc(c)));
        chk(16'(sel), 16'(c));
        dce = 0;
        slp = 0;
        rd(8'h23, v);
      end
    end
    $display("test durations done");
    prof = 3'h2;
    dce = 1;
    repeat (10) @(negedge clock_in);
    chk({run, appl}, 2'b11);
    dis = 1;
    @(negedge clock_in);
    repeat (300) begin
      @(negedge clock_in);
      chk({run, exp_p}, 2'b00);
    end
    dis = 0;
    prof = 3'(5 + $urandom % 3);
    repeat (20) begin
      @(negedge clock_in);
      chk({run, appl}, 2'b00);
    end
    dce = 0;
    $display("test disable done");
    print_verdict;
  end
endmodule
